/* pkg/eep_consts.vh */
`ifndef EEP_CONSTS_VH
`define EEP_CONSTS_VH

// ****************************************************************
// Array geometry
// ****************************************************************
`define EEP_ADDR_W      15
`define EEP_MEM_WORDS   32768
`define EEP_PAGE_BITS   6
`define EEP_PAGE_LAST   6'h3f

// ****************************************************************
// Control byte
// ****************************************************************
// Device type code: value is arbitrary
`define EEP_TYPE_CODE   4'h5
`define EEP_RW_READ     1'b1

// ****************************************************************
// Write buffer
// ****************************************************************
`define EEP_FIFO_DEPTH  8
`define EEP_FIFO_AW     3
`define EEP_FIFO_WIDTH  14

// ****************************************************************
// Timing
// ****************************************************************
`define EEP_CLK_NS      50
`define EEP_TWC_NS      5000000
`define EEP_TWC_CYCLES  (`EEP_TWC_NS / `EEP_CLK_NS)

`endif

/* rtl/eep_fifo.v */
`default_nettype none

module eep_fifo #(
  parameter WIDTH = 14,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = store[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // eep_fifo

`default_nettype wire

/* rtl/eep_top.v */
`include "eep_consts.vh"
`default_nettype none

// Function
// - Protect pin high blocks all array writes
// - Protect pin low means normal writes
// - Protect pin sampled only at Stop
// - Page write stays within one page
// - Page overrun wraps to page start
// - No acknowledge while write cycle runs
// - Stop after write starts timed cycle
// - Read/write bit one selects a read
// - Counter holds last address plus one
// - Read control acked, then byte sent
// - Address loaded before repeated Start
// - After random read, counter points next
// - Master ack requests next sequential byte
// - Pointer increments as each read byte is loaded, and after each write byte
// - Pointer wraps from top to zero
// - Page buffer 64 bytes, six bits increment
// - Protected write acked, no cycle, ready
// - Ack only on full control match
// - Two address bytes, top bit ignored
module eep_top #(
  parameter TWC_CYCLES = `EEP_TWC_CYCLES
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Two-wire bus
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  // Pins
  input  wire       wp,
  input  wire [2:0] chip_select_bits,
  // Status
  output reg        write_busy
);

  // ****************************************************************
  // Protocol states
  // ****************************************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RX   = 3'h1;
  localparam [2:0] ST_ACK  = 3'h2;
  localparam [2:0] ST_TX   = 3'h3;
  localparam [2:0] ST_MACK = 3'h4;

  localparam [1:0] WC_IDLE = 2'h0;
  localparam [1:0] WC_COPY = 2'h1;
  localparam [1:0] WC_TIME = 2'h2;

  localparam [1:0] IDX_CTRL  = 2'h0;
  localparam [1:0] IDX_ADDRH = 2'h1;
  localparam [1:0] IDX_ADDRL = 2'h2;
  localparam [1:0] IDX_DATA  = 2'h3;

  function [`EEP_ADDR_W-1:0] next_page_addr;
    input [`EEP_ADDR_W-1:0] a;
    begin
      next_page_addr = {a[`EEP_ADDR_W-1:`EEP_PAGE_BITS],
                        a[`EEP_PAGE_BITS-1:0] + 6'h01};
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  reg       scl_s1;
  reg       scl_s2;
  reg       scl_d;
  reg       sda_s1;
  reg       sda_s2;
  reg       sda_d;
  reg       wp_s1;
  reg       wp_s2;
  reg [2:0] cs_s1;
  reg [2:0] cs_s2;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
      wp_s1  <= 1'b0;
      wp_s2  <= 1'b0;
      cs_s1  <= 3'h0;
      cs_s2  <= 3'h0;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
      wp_s1  <= wp;
      wp_s2  <= wp_s1;
      cs_s1  <= chip_select_bits;
      cs_s2  <= cs_s1;
    end
  end

  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire stop_det  = scl_s2 & scl_d & ~sda_d & sda_s2;

  // ****************************************************************
  // Storage and write buffer
  // ****************************************************************
  reg  [7:0]             mem [0:`EEP_MEM_WORDS-1];
  reg  [7:0]             rd_data;
  reg  [7:0]             pb_data [0:`EEP_PAGE_LAST];
  reg  [63:0]            pb_valid;
  reg  [1:0]             wc_state;
  reg  [5:0]             cidx;
  reg  [16:0]            wc_timer;
  reg  [`EEP_ADDR_W-1:0] ptr;
  reg                    f_in_valid;
  reg  [13:0]            f_in_data;
  wire                   f_in_ready;
  wire                   f_out_valid;
  wire [13:0]            f_out_data;
  wire                   f_out_ready = (wc_state == WC_IDLE);
  wire                   busy = (wc_state != WC_IDLE);

  // Page bytes pass through a small FIFO so the bus side never waits on the copy
  eep_fifo #(
    .WIDTH (`EEP_FIFO_WIDTH),
    .DEPTH (`EEP_FIFO_DEPTH),
    .AW    (`EEP_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  always @(posedge clk) begin
    rd_data <= mem[ptr];
    if (f_out_valid && f_out_ready) begin
      pb_data[f_out_data[13:8]] <= f_out_data[7:0];
    end
    if (wc_state == WC_COPY && !f_out_valid && pb_valid[cidx]) begin
      mem[{ptr[`EEP_ADDR_W-1:`EEP_PAGE_BITS], cidx}] <= pb_data[cidx];
    end
  end

  // ****************************************************************
  // Self-timed write cycle
  // ****************************************************************
  reg wr_pend;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wc_state   <= WC_IDLE;
      cidx       <= 6'h00;
      wc_timer   <= 17'h00000;
      pb_valid   <= 64'h0;
      write_busy <= 1'b0;
    end else begin
      write_busy <= busy;
      case (wc_state)
        WC_IDLE: begin
          if (f_out_valid) begin
            pb_valid[f_out_data[13:8]] <= 1'b1;
          end
          if (stop_det && wr_pend) begin
            if (wp_s2) begin
              pb_valid <= 64'h0;
            end else begin
              wc_state <= WC_COPY;
              cidx     <= 6'h00;
            end
          end else if (start_det) begin
            pb_valid <= 64'h0;
          end
        end
        WC_COPY: begin
          if (!f_out_valid) begin
            cidx <= cidx + 6'h01;
            if (cidx == `EEP_PAGE_LAST) begin
              wc_state <= WC_TIME;
              wc_timer <= 17'h00000;
            end
          end
        end
        WC_TIME: begin
          if (wc_timer >= TWC_CYCLES - 1) begin
            wc_state <= WC_IDLE;
            pb_valid <= 64'h0;
          end else begin
            wc_timer <= wc_timer + 17'h00001;
          end
        end
        default: begin
          wc_state <= WC_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Bus protocol engine
  // ****************************************************************
  reg [2:0] state;
  reg [3:0] bitc;
  reg [7:0] shreg;
  reg [7:0] txreg;
  reg [1:0] idx;
  reg       is_read;
  reg       mack;
  reg [6:0] addr_hi;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      bitc       <= 4'h0;
      shreg      <= 8'h00;
      txreg      <= 8'h00;
      idx        <= IDX_CTRL;
      is_read    <= 1'b0;
      mack       <= 1'b0;
      addr_hi    <= 7'h00;
      ptr        <= 15'h0000;
      wr_pend    <= 1'b0;
      sda_out    <= 1'b0;
      sda_oe     <= 1'b0;
      f_in_valid <= 1'b0;
      f_in_data  <= 14'h0000;
    end else begin
      f_in_valid <= 1'b0;
      if (start_det) begin
        state   <= ST_RX;
        bitc    <= 4'h0;
        idx     <= IDX_CTRL;
        wr_pend <= 1'b0;
        sda_oe  <= 1'b0;
      end else if (stop_det) begin
        state   <= ST_IDLE;
        wr_pend <= 1'b0;
        sda_oe  <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_RX: begin
            if (scl_rise && bitc != 4'h8) begin
              shreg <= {shreg[6:0], sda_s2};
              bitc  <= bitc + 4'h1;
            end else if (scl_fall && bitc == 4'h8) begin
              state <= ST_ACK;
              bitc  <= 4'h0;
              case (idx)
                IDX_CTRL: begin
                  if (shreg[7:4] == `EEP_TYPE_CODE && shreg[3:1] == cs_s2 && !busy) begin
                    sda_oe <= 1'b1;
                    is_read <= (shreg[0] == `EEP_RW_READ);
                  end else begin
                    state <= ST_IDLE;
                  end
                end
                IDX_ADDRH: begin
                  addr_hi <= shreg[6:0];
                  sda_oe  <= 1'b1;
                end
                IDX_ADDRL: begin
                  ptr    <= {addr_hi, shreg};
                  sda_oe <= 1'b1;
                end
                IDX_DATA: begin
                  if (f_in_ready) begin
                    f_in_valid <= 1'b1;
                    f_in_data  <= {ptr[`EEP_PAGE_BITS-1:0], shreg};
                    ptr     <= next_page_addr(ptr);
                    wr_pend <= 1'b1;
                    sda_oe  <= 1'b1;
                  end
                end
                default: begin
                  state <= ST_IDLE;
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (is_read) begin
                state   <= ST_TX;
                txreg   <= {rd_data[6:0], 1'b0};
                sda_oe  <= ~rd_data[7];
                bitc    <= 4'h1;
                ptr     <= ptr + 15'h0001;
              end else begin
                state  <= ST_RX;
                sda_oe <= 1'b0;
                if (idx != IDX_DATA) begin
                  idx <= idx + 2'h1;
                end
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bitc == 4'h8) begin
                state  <= ST_MACK;
                sda_oe <= 1'b0;
                mack   <= 1'b0;
              end else begin
                sda_oe <= ~txreg[7];
                txreg  <= {txreg[6:0], 1'b0};
                bitc   <= bitc + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              mack <= ~sda_s2;
            end else if (scl_fall) begin
              if (mack) begin
                state  <= ST_TX;
                txreg  <= {rd_data[6:0], 1'b0};
                sda_oe <= ~rd_data[7];
                bitc   <= 4'h1;
                ptr    <= ptr + 15'h0001;
              end else begin
                state  <= ST_IDLE;
                sda_oe <= 1'b0;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // eep_top

`default_nettype wire

/* bench/eep_props.sv */
`default_nettype none
module eep_props #(
  parameter TWC_CYCLES = 50
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Bus
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // Pins and status
  input wire logic       wp,
  input wire logic [2:0] chip_select_bits,
  input wire logic       write_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  int busy_cnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= write_busy ? busy_cnt + 1 : 0;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_oe_pulls_low: assert property (sda_oe |-> !sda_out && !sda_in)
    else $error("driven bit not low on the line");
  chk_oe_stands: assert property ($rose(sda_oe) |-> sda_oe[*6])
    else $error("driven low bit too short");
  chk_oe_in_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("data changed while clock high");
  chk_busy_quiet: assert property (write_busy |-> !sda_oe)
    else $error("line driven during write cycle");
  chk_busy_at_stop: assert property ($rose(write_busy) |-> scl_in && sda_in)
    else $error("write cycle began outside a stop");
  chk_busy_len: assert property ($fell(write_busy) |-> busy_cnt == 64 + TWC_CYCLES)
    else $error("write cycle length wrong");
  chk_busy_bound: assert property ($rose(write_busy) |-> ##[1:1000] !write_busy)
    else $error("write cycle never ended");
  chk_wp_blocks: assert property ($rose(write_busy) |-> !$past(wp, 4))
    else $error("write cycle while protected");
endmodule // eep_props
`default_nettype wire

/* bench/eep_master.sv */
`default_nettype none
module eep_master (
  // Bus
  output var logic scl,
  output var logic sda_m,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  // Clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic xbit(input logic b, output logic r);
    #50;
    sda_m = b;
    #200;
    scl = 1'b1;
    #100;
    r = sda;
    #50;
    scl = 1'b0;
  endtask
  task automatic start();
    #50;
    sda_m = 1'b1;
    #200;
    scl = 1'b1;
    #150;
    sda_m = 1'b0;
    #150;
    scl = 1'b0;
  endtask
  task automatic stop();
    #50;
    sda_m = 1'b0;
    #200;
    scl = 1'b1;
    #150;
    sda_m = 1'b1;
    #200;
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
    end
    xbit(1'b1, r);
    ack = !r;
  endtask
  task automatic rx(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(!more, r);
  endtask
endmodule // eep_master
`default_nettype wire

/* bench/eep_top_test.sv */
`include "eep_consts.vh"
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module eep_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TWC = 50;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       wp = 1'b0;
  logic [2:0] cs = 3'h0;
  wire logic  scl;
  wire logic  sda_m;
  wire logic  sda;
  wire logic  sda_out;
  wire logic  sda_oe;
  wire logic  write_busy;
  int         failures = 0;
  int         checks = 0;
  int         n;
  logic       ack;
  logic [7:0] d;
  logic [7:0] dat [5];
  always #25 clk = ~clk;
  // Open drain with pull-up
  assign sda = (sda_oe ? sda_out : 1'b1) & sda_m;
  eep_top #(.TWC_CYCLES(TWC)) dut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .wp(wp), .chip_select_bits(cs),
    .write_busy(write_busy));
  eep_master m (.scl(scl), .sda_m(sda_m), .sda(sda));
  function automatic logic [15:0] pg_wrap(logic [14:0] a, int k);
    return {1'b0, a[14:6], 6'(a[5:0] + k)};
  endfunction
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic drv_wp(input logic v);
    @(posedge clk);
    #5 wp = v;
  endtask
  task automatic hdr(input logic rw);
    m.start();
    m.tx({`EEP_TYPE_CODE, cs, rw}, ack);
  endtask
  task automatic addr(input logic [15:0] a);
    hdr(1'b0);
    `CHK(ack, 1'b1)
    m.tx(a[15:8], ack);
    `CHK(ack, 1'b1)
    m.tx(a[7:0], ack);
    `CHK(ack, 1'b1)
  endtask
  task automatic rd(input int k, input logic [7:0] q[$]);
    hdr(1'b1);
    `CHK(ack, 1'b1)
    for (int i = 0; i < k; i++) begin
      m.rx(i < k - 1, d);
      `CHK(d, q[i])
    end
    m.stop();
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] q[$]);
    addr(a);
    foreach (q[i]) begin
      m.tx(q[i], ack);
      `CHK(ack, 1'b1)
    end
    m.stop();
  endtask
  task automatic poll();
    for (n = 0; n < 60; n++) begin
      hdr(1'b0);
      if (ack === 1'b1) begin
        break;
      end
    end
    m.stop();
    if (n == 60) begin
      failures++;
      stop_test();
    end
  endtask
  initial begin
    void'($urandom(32'h146b));
    cs = 3'($urandom);
    foreach (dat[i]) begin
      dat[i] = 8'($urandom);
    end
    repeat (12) @(posedge clk);
    #5 rst_n = 1'b1;
    repeat (8) @(posedge clk);
    // Keep every master change off the sampling edge
    #5;
    // Wrong type code, then wrong select bits
    m.start();
    m.tx({~`EEP_TYPE_CODE, cs, 1'b0}, ack);
    `CHK(ack, 1'b0)
    m.start();
    m.tx({`EEP_TYPE_CODE, ~cs, 1'b0}, ack);
    `CHK(ack, 1'b0)
    m.stop();
    // Overrun from the top byte of the array: breaks the split on purpose
    wr(16'hffff, '{dat[0], dat[1], dat[2], dat[3]});
    drv_wp(1'b1);
    repeat (4) @(posedge clk);
    #5;
    `CHK(write_busy, 1'b1)
    poll();
    `CHK(n > 0, 1'b1)
    drv_wp(1'b0);
    addr(pg_wrap(15'h7fff, 1));
    rd(3, '{dat[1], dat[2], dat[3]});
    addr(pg_wrap(15'h7fff, 2));
    rd(1, '{dat[2]});
    rd(1, '{dat[3]});
    wr(16'h0000, '{dat[4]});
    poll();
    // Protected write leaves old data and no cycle
    drv_wp(1'b1);
    wr(16'h0000, '{~dat[4]});
    drv_wp(1'b0);
    repeat (10) @(posedge clk);
    #5;
    `CHK(write_busy, 1'b0)
    addr(16'h7fff);
    rd(2, '{dat[0], dat[4]});
    stop_test();
  end
endmodule // eep_top_test
bind eep_top eep_props #(.TWC_CYCLES(TWC_CYCLES)) props (.clk(clk), .rst_n(rst_n),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .wp(wp),
  .chip_select_bits(chip_select_bits), .write_busy(write_busy));
`default_nettype wire
